// ---- dtb_readout.sv ----
// Purpose: APB readout and fill count of a 64 x 20-bit debug trace buffer.
// Assumes: All inputs are synchronous to pclk; presetn is the power-on reset.
// Notes:   First read of a line gives bits 19:16, second gives bits 15:0.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "dtb_defs.svh"

// What this block does
// - 20-bit line read as two 16-bit reads.
// - Each valid window read advances read pointer.
// - Arming locks the buffer against reads.
// - Aligned word write while disarmed unlocks buffer.
// - Valid read needs unlocked, unsecured, disarmed, request.
// - Misaligned reads return zero, pointer holds.
// - Armed or no-request reads return zero.
// - Storage unreset; system reset clears only the control register.
// - Count register is read-only, always readable.
// - Full flag bit 7 after 64 lines.
// - Arming clears count and full flag.
// - Only power-on reset and arming clear count and flag.
// - Count bits 5..0 give valid lines.
// - Wrap sets full; end-align keeps counting.
// - Reading never decrements the count.
// - Begin-align full clears arm, ends session.
// - Full with nonzero count: oldest overwritten.
// - Full flag mirrored in status bit 7.
// - Per-state next-state control registers.
// - View select picks shared-address register.
// - Align bit: 0 end, 1 begin.
// - Request bit cannot be set while secured.
module dtb_readout (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                sys_reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                secured,
  input  wire logic                trace_line_valid,
  input  wire dtb_pkg::dtb_line_t  trace_line_data,
  input  wire logic [2:0]          match_flags,
  output logic                     session_armed_out,
  output logic                     capture_active
);
  import dtb_pkg::*;

  // Index compare, used by every decode term.
  function automatic logic at_idx(input logic [11:0] a, input logic [9:0] i);
    at_idx = (a[11:2] == i);
  endfunction

  dtb_line_t   trace_mem [0:`DTB_LINES-1];
  dtb_ctrl_t   ctrl_reg;
  logic        locked_reg;
  logic [6:0]  rptr_reg;
  logic [5:0]  count_reg;
  logic        full_reg;
  logic [3:0]  seq_reg [0:2];
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        cap_reg;
  logic        win_ok_reg;

  // Bus phase decode.
  wire setup_ph = psel & ~penable;
  wire wr_acc   = psel & penable & pready_reg & pwrite;
  wire rd_acc   = psel & penable & pready_reg & ~pwrite;
  wire hit_ctrl = at_idx(paddr, `DTB_IDX_CTRL);
  wire hit_stat = at_idx(paddr, `DTB_IDX_STAT);
  wire hit_win  = at_idx(paddr, `DTB_IDX_WIN);
  wire hit_cnt  = at_idx(paddr, `DTB_IDX_CNT);
  wire hit_seq  = at_idx(paddr, `DTB_IDX_SEQ);
  wire mapped   = hit_ctrl | hit_stat | hit_win | hit_cnt | hit_seq;

  // Readout gating; the pointer steps only on a read that returns data; an unlock reloads it.
  wire aligned   = (paddr[1:0] == 2'b00);
  wire rd_ok     = ~locked_reg & ~secured & ~ctrl_reg.session_armed
                   & ctrl_reg.trace_request_bit;
  wire win_valid = hit_win & aligned & rd_ok;
  wire win_step  = rd_acc & win_ok_reg;

  // Control writes and their side effects.
  wire ctrl_wr   = wr_acc & hit_ctrl & pstrb[0];
  wire arm_write = ctrl_wr & pwdata[`DTB_CTRL_ARM];
  wire unlock_wr = wr_acc & hit_win & aligned & (pstrb[1:0] == 2'b11)
                   & ~ctrl_reg.session_armed;
  wire seq_wr    = wr_acc & hit_seq & pstrb[0] & ~ctrl_reg.session_armed;

  // Capture: a line is stored only in an armed session with tracing asked.
  wire cap_go    = trace_line_valid & ctrl_reg.session_armed
                   & ctrl_reg.trace_request_bit & ~secured;
  wire wrap      = cap_go & (count_reg == `DTB_CNT_MAX);
  wire begin_end = wrap & ctrl_reg.trigger_align_bit;

  // Oldest line: slot zero until full, then the next slot to be overwritten.
  wire [6:0] oldest = full_reg ? {count_reg, 1'b0} : 7'h00;

  // Read data of the current window half.
  dtb_line_t cur_line;
  logic [15:0] win_half;
  assign cur_line = trace_mem[rptr_reg[6:1]];
  assign win_half = rptr_reg[0] ? cur_line[15:0] : {12'h000, cur_line[19:16]};

  // Shared-address view; the match flags sit behind the last code.
  logic [3:0] seq_view;
  assign seq_view = (ctrl_reg.view_select_field == DTB_VIEW_MATCH) ? {1'b0, match_flags}
                    : seq_reg[ctrl_reg.view_select_field];

  // Read mux, decoded in the setup cycle.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_word = {26'h000_0000, ctrl_reg.view_select_field, 1'b0, ctrl_reg.trace_request_bit,
                 ctrl_reg.trigger_align_bit, ctrl_reg.session_armed};
    end else if (hit_stat) begin
      rd_word[`DTB_FULL_BIT] = full_reg;
    end else if (hit_win) begin
      if (win_valid) begin
        rd_word = {16'h0000, win_half};
      end
    end else if (hit_cnt) begin
      rd_word = {24'h00_0000, full_reg, 1'b0, count_reg};
    end else if (hit_seq) begin
      rd_word = {28'h000_0000, seq_view};
    end
  end

  // Bus answer registers: one wait-free access phase after setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Window validity is frozen at setup, so the pointer steps exactly when data was returned.
  // Without it, a change of secured between setup and access could return data without a step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_ok_reg <= 1'b0;
    end else begin
      win_ok_reg <= setup_ph & ~pwrite & win_valid;
    end
  end

  // Control register; a system reset disarms but keeps the fill state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= dtb_ctrl_t'(`DTB_CTRL_RST);
    end else if (sys_reset) begin
      ctrl_reg <= dtb_ctrl_t'(`DTB_CTRL_RST);
    end else if (ctrl_wr) begin
      ctrl_reg.session_armed <= pwdata[`DTB_CTRL_ARM];
      ctrl_reg.view_select_field <= dtb_view_t'(pwdata[`DTB_CTRL_VSEL +: 2]);
      if (!ctrl_reg.session_armed) begin
        ctrl_reg.trigger_align_bit <= pwdata[`DTB_CTRL_ALIGN];
      end
      if (!secured || !pwdata[`DTB_CTRL_REQ]) begin
        ctrl_reg.trace_request_bit <= pwdata[`DTB_CTRL_REQ];
      end
    end else if (begin_end) begin
      ctrl_reg.session_armed <= 1'b0;
    end
  end

  // Lock and read pointer; stored lines are never touched here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_reg <= 1'b1;
      rptr_reg   <= 7'h00;
    end else if (arm_write) begin
      locked_reg <= 1'b1;
    end else if (unlock_wr) begin
      locked_reg <= 1'b0;
      rptr_reg   <= oldest;
    end else if (win_step) begin
      rptr_reg   <= rptr_reg + 7'h01;
    end
  end

  // Fill count and full flag survive system resets; reads never touch them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 6'h00;
      full_reg  <= 1'b0;
    end else if (arm_write) begin
      count_reg <= 6'h00;
      full_reg  <= 1'b0;
    end else if (cap_go) begin
      count_reg <= count_reg + 6'h01;
      full_reg  <= full_reg | wrap;
    end
  end

  // Storage has no reset, so its content after power-on is undefined.
  always_ff @(posedge pclk) begin
    if (cap_go) begin
      trace_mem[count_reg] <= trace_line_data;
    end
  end

  // Per-state next-state controls, writable only while disarmed.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_seq
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          seq_reg[gi] <= `DTB_SEQ_RST;
        end else if (seq_wr && ctrl_reg.view_select_field == dtb_view_t'(gi)) begin
          seq_reg[gi] <= pwdata[3:0];
        end
      end
    end
  endgenerate

  // Status outputs, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= 1'b0;
    end else begin
      cap_reg <= cap_go;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign session_armed_out = ctrl_reg.session_armed;
  assign capture_active    = cap_reg;

  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_win_setup_rd;
    setup_ph && !pwrite && hit_win;
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  sequence s_seq_setup_rd;
    setup_ph && !pwrite && hit_seq;
  endsequence

  // Fill count, full flag and session end.
  chk_wrap_sets_full: assert property (wrap && !arm_write |=> full_reg)
    else $error("full flag not set on count wrap");

  chk_end_keeps_armed: assert property (
      wrap && !ctrl_reg.trigger_align_bit && !ctrl_wr && !sys_reset
      |=> session_armed_out && count_reg == 6'h00)
    else $error("end-aligned session stopped on wrap");

  chk_begin_disarms: assert property (
      begin_end && !ctrl_wr && !sys_reset
      |=> !session_armed_out ##1 !capture_active)
    else $error("begin-aligned session not ended when full");

  chk_begin_full_state: assert property (
      begin_end && !arm_write
      |=> full_reg && count_reg == 6'h00)
    else $error("begin-aligned fill did not end full at count zero");

  chk_arm_clears_count: assert property (
      arm_write
      |=> count_reg == 6'h00 && !full_reg && locked_reg)
    else $error("arming did not clear count and lock buffer");

  chk_count_steady: assert property (
      !cap_go && !arm_write
      |=> $stable(count_reg) && $stable(full_reg))
    else $error("count changed without capture or arming");

  chk_capture_counts: assert property (
      cap_go && !arm_write
      |=> count_reg == $past(count_reg) + 6'h01)
    else $error("capture did not add one to the count");

  chk_capture_seen: assert property (cap_go |=> capture_active)
    else $error("stored line not reported as capture");

  chk_full_sticky: assert property (full_reg && !arm_write |=> full_reg)
    else $error("full flag dropped without arming");

  chk_sysreset_keeps_fill: assert property (
      sys_reset && !cap_go && !arm_write
      |=> $stable(count_reg) && $stable(full_reg))
    else $error("system reset disturbed the fill state");

  chk_count_readable: assert property (
      setup_ph && !pwrite && hit_cnt
      |=> pready && prdata[5:0] == $past(count_reg) && prdata[7] == $past(full_reg))
    else $error("count register read did not show count and flag");

  chk_count_write_ignored: assert property (
      wr_acc && hit_cnt && !cap_go && !arm_write
      |=> $stable(count_reg) && $stable(full_reg))
    else $error("write to count register took effect");

  chk_status_mirror: assert property (
      setup_ph && !pwrite && hit_stat
      |=> prdata[7] == $past(full_reg))
    else $error("status bit 7 does not mirror full flag");

  // Window gating, lock and read pointer.
  chk_bad_read_zero: assert property (
      s_win_setup_rd ##0 !win_valid
      |=> prdata == 32'h0000_0000)
    else $error("invalid window read returned data");

  chk_armed_read_zero: assert property (
      s_win_setup_rd ##0 ctrl_reg.session_armed
      |=> prdata == 32'h0000_0000)
    else $error("window read while armed returned data");

  chk_locked_read_zero: assert property (
      s_win_setup_rd ##0 locked_reg
      |=> prdata == 32'h0000_0000)
    else $error("window read while locked returned data");

  chk_secured_read_zero: assert property (
      s_win_setup_rd ##0 secured
      |=> prdata == 32'h0000_0000)
    else $error("window read while secured returned data");

  chk_misaligned_hold: assert property (
      rd_acc && hit_win && !aligned && !arm_write
      |=> $stable(rptr_reg))
    else $error("misaligned read moved pointer");

  chk_read_step: assert property (
      s_win_setup_rd ##0 win_valid ##1 s_access_done
      |=> rptr_reg == $past(rptr_reg) + 7'h01)
    else $error("valid window read did not advance pointer");

  chk_pointer_quiet: assert property (
      !win_step && !unlock_wr
      |=> $stable(rptr_reg))
    else $error("read pointer moved without a valid read");

  chk_unlock_oldest: assert property (
      unlock_wr
      |=> !locked_reg && rptr_reg == $past(oldest))
    else $error("unlock did not point at oldest line");

  chk_lock_holds: assert property (locked_reg && !unlock_wr |=> locked_reg)
    else $error("buffer unlocked without an unlock write");

  chk_armed_no_unlock: assert property (
      wr_acc && hit_win && ctrl_reg.session_armed
      |=> locked_reg)
    else $error("window write while armed unlocked the buffer");

  // Control and shared-address registers.
  chk_secured_request: assert property (
      ctrl_wr && secured && !ctrl_reg.trace_request_bit && !sys_reset
      |=> !ctrl_reg.trace_request_bit)
    else $error("request bit set while secured");

  chk_align_armed_hold: assert property (
      ctrl_wr && ctrl_reg.session_armed && !sys_reset
      |=> $stable(ctrl_reg.trigger_align_bit))
    else $error("align bit changed during a session");

  chk_seq_armed_hold: assert property (
      wr_acc && hit_seq && ctrl_reg.session_armed
      |=> $stable(seq_reg[0]) && $stable(seq_reg[1]) && $stable(seq_reg[2]))
    else $error("state control written while armed");

  chk_match_view: assert property (
      s_seq_setup_rd ##0 ctrl_reg.view_select_field == DTB_VIEW_MATCH
      |=> prdata == {29'h000_0000, $past(match_flags)})
    else $error("match view did not show the match flags");

endmodule

// ---- dtb_defs.svh ----
// Purpose: Offsets, field positions, reset values for the trace buffer readout.
// Assumes: APB register index = paddr[11:2]; byte address is four times it.
// Notes:   Definitions only.
`ifndef DTB_DEFS_SVH
`define DTB_DEFS_SVH

// Register indices (byte address = index * 4).
`define DTB_IDX_CTRL    10'h020
`define DTB_IDX_STAT    10'h021
`define DTB_IDX_WIN     10'h024
`define DTB_IDX_CNT     10'h026
`define DTB_IDX_SEQ     10'h027

// Control register field positions.
`define DTB_CTRL_ARM    0
`define DTB_CTRL_ALIGN  1
`define DTB_CTRL_REQ    2
`define DTB_CTRL_VSEL   4

// Full flag position in count and status registers.
`define DTB_FULL_BIT    7

// Geometry and reset values.
`define DTB_LINES       64
`define DTB_LINE_W      20
`define DTB_CNT_MAX     6'h3F
`define DTB_CTRL_RST    5'h00
`define DTB_SEQ_RST     4'h0

`endif

// ---- dtb_pkg.sv ----
// Purpose: Types shared by the trace buffer readout.
// Assumes: Nothing beyond the defs header.
// Notes:   Control bits travel as one packed struct.
package dtb_pkg;

  // Window at the shared sequencer address.
  typedef enum logic [1:0] {
    DTB_VIEW_S1,
    DTB_VIEW_S2,
    DTB_VIEW_S3,
    DTB_VIEW_MATCH
  } dtb_view_t;

  // Software control word.
  typedef struct packed {
    dtb_view_t view_select_field;
    logic      trace_request_bit;
    logic      trigger_align_bit;
    logic      session_armed;
  } dtb_ctrl_t;

  // One stored trace line.
  typedef logic [19:0] dtb_line_t;

endpackage

// ---- dtb_host_model.sv ----
// Purpose: APB master that stands in for the CPU or debug host.
// Assumes: The slave answers with pready; only the bench watchdog bounds the wait.
// Notes:   Signals change only just after a rising edge.
`timescale 1ns/1ps
module dtb_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  // Bus is idle from time zero.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end

  // One transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (!pready); // A dead slave is caught by the bench watchdog.
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ---- tb_debug_trace_buffer_readout.sv ----
// Purpose: Self-checking bench for the trace buffer readout.
// Assumes: Slave answers through pready; captures need arm and request.
// Notes:   Expected reads are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module tb_debug_trace_buffer_readout;
  import dtb_pkg::*;
  logic        pclk, presetn, sys_reset, psel, penable, pwrite, pready, pslverr;
  logic        secured, trace_line_valid, session_armed_out, capture_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0]  pstrb;
  logic [2:0]  match_flags;
  dtb_line_t   trace_line_data;
  dtb_line_t   mem [64];
  logic [32:0] expq [$];
  int          n_errors, checks_done, wp, cnt;
  bit          full;

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  dtb_readout i_dtb_readout (.pclk(pclk), .presetn(presetn), .sys_reset(sys_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .secured(secured), .trace_line_valid(trace_line_valid),
    .trace_line_data(trace_line_data), .match_flags(match_flags), .session_armed_out(session_armed_out),
    .capture_active(capture_active));
  dtb_host_model u_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    u_host.xfer(1'b0, a, lfsr(seed), 4'h0);
  endtask

  // Arming also restarts the bench's own fill model.
  task automatic arm(input logic [31:0] c);
    wr(12'h080, c);
    {wp, cnt, full} = '0;
  endtask

  function automatic logic [32:0] cnt_exp();
    return {25'h0, full, 1'b0, cnt[5:0]};
  endfunction

  // Both halves of one stored line, high nibble first.
  task automatic rdline(input int i);
    rd(12'h090, {29'h0, mem[i][19:16]});
    rd(12'h090, {17'h0, mem[i][15:0]});
  endtask

  // Back-to-back capture pulses with pseudo-random line data.
  task automatic capture(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      seed = lfsr(seed);
      trace_line_valid <= 1'b1;
      trace_line_data <= seed[19:0];
      mem[wp] = seed[19:0];
      wp = (wp + 1) % 64;
      cnt = (cnt + 1) % 64;
      if (cnt == 0) full = 1'b1;
    end
    @(posedge pclk);
    trace_line_valid <= 1'b0;
  endtask

  // Each completed read is matched against the oldest queued expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
      else chk(33'h0, 33'h1);
    end
  end

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (8000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    {presetn, sys_reset, secured, trace_line_valid, trace_line_data, match_flags} = '0;
    seed = 32'd94269;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h098, 33'h0);
    rd(12'h090, 33'h0);
    arm(32'h5);
    capture(5);
    rd(12'h098, cnt_exp());
    wr(12'h098, 32'hFF);
    rd(12'h098, cnt_exp());
    rd(12'h090, 33'h0);
    wr(12'h080, 32'h4);
    rd(12'h090, 33'h0);
    wr(12'h090, 32'h0);
    rd(12'h092, 33'h0);
    @(posedge pclk);
    secured <= 1'b1;
    rd(12'h090, 33'h0);
    secured <= 1'b0;
    wr(12'h080, 32'h0);
    // A request written while secured must be refused.
    secured <= 1'b1;
    wr(12'h080, 32'h4);
    secured <= 1'b0;
    rd(12'h090, 33'h0);
    rd(12'h080, 33'h0);
    wr(12'h080, 32'h4);
    rdline(0);
    rdline(1);
    rd(12'h098, cnt_exp());
    @(posedge pclk);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rd(12'h098, cnt_exp());
    rd(12'h090, 33'h0);
    wr(12'h080, 32'h4);
    rdline(2);
    // End alignment keeps counting past the wrap.
    arm(32'h5);
    wr(12'h090, 32'h0);
    capture(66);
    wr(12'h080, 32'h4);
    rd(12'h090, 33'h0);
    rd(12'h084, 33'h80);
    rd(12'h098, cnt_exp());
    wr(12'h090, 32'h0);
    rdline(2);
    rdline(3);
    // Begin alignment ends the session when the buffer fills.
    arm(32'h7);
    capture(64);
    // The disarm lands at the edge that ended the capture; look one edge later.
    @(posedge pclk);
    chk({32'h0, session_armed_out}, 33'h0);
    rd(12'h098, cnt_exp());
    for (int v = 0; v < 3; v++) begin
      wr(12'h080, 32'h4 | (v << 4));
      wr(12'h09C, 32'h9 + v);
      rd(12'h09C, 33'h9 + v);
    end
    @(posedge pclk);
    match_flags <= seed[2:0];
    wr(12'h080, 32'h34);
    rd(12'h09C, {30'h0, seed[2:0]});
    rd(12'h080, 33'h34);
    arm(32'h5);
    rd(12'h098, 33'h0);
    rd(12'h0FC, 33'h1_0000_0000);
    wr(12'h09C, 32'h5);
    rd(12'h09C, 33'h9);
    capture(3);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    {cnt, full} = '0;
    rd(12'h098, cnt_exp());
    repeat (3) @(posedge pclk);
    tally_and_finish();
  end
endmodule
